// *** hw/uacr_consts.vh ***
// constants for the auxiliary configuration report block
`ifndef UACR_CONSTS_VH
`define UACR_CONSTS_VH
// bus address is {report id, byte offset}
`define UACR_ID_LOOP      8'h55
`define UACR_ID_IR        8'h56
`define UACR_ID_DELAY     8'h57
`define UACR_ID_THRESH    8'h58
`define UACR_ID_USBCFG    8'h60
// byte offsets inside the descriptor programming, threshold and control reports
`define UACR_OFS_VID_LO   4'h1
`define UACR_OFS_VID_HI   4'h2
`define UACR_OFS_PID_LO   4'h3
`define UACR_OFS_PID_HI   4'h4
`define UACR_OFS_POWER    4'h5
`define UACR_OFS_ATTR     4'h6
`define UACR_OFS_REL_MAJ  4'h7
`define UACR_OFS_REL_MIN  4'h8
`define UACR_OFS_FLUSH    4'h9
`define UACR_OFS_SELECT   4'hA
`define UACR_OFS_THR_MSB  4'h1
`define UACR_OFS_THR_LSB  4'h2
`define UACR_OFS_CTRL     4'h1
// field masks
`define UACR_LOOP_MASK    8'h07
`define UACR_IR_MASK      8'h07
`define UACR_DELAY_MASK   8'h0F
`define UACR_ATTR_MASK    8'h0F
`define UACR_FLUSH_MASK   8'h0F
// select bits
`define UACR_SEL_VID      0
`define UACR_SEL_PID      1
`define UACR_SEL_ATTR     2
`define UACR_SEL_POWER    3
`define UACR_SEL_REL      4
`define UACR_SEL_FLUSH    5
// reset values
`define UACR_THR_RST      9'h1C2
`define UACR_POWER_RST    8'h32
`define UACR_ATTR_RST     8'h00
`define UACR_FLUSH_RST    8'h05
`define UACR_REL_RST      16'h0100
// flow-control modes
`define UACR_FLOW_HW      3'h1
`define UACR_FLOW_SW      3'h2
// infrared pulse slots within 16 sub-bit ticks
`define UACR_IR_SLOT_LO   4'h6
`define UACR_IR_SLOT_HI3  4'h8
`define UACR_IR_SLOT_HI4  4'h9
`endif

// *** hw/uacr_top.v ***
// auxiliary uart configuration report decoder and its datapath controls
//
// Notes on behaviour
// - report 0x55 holds loopback control byte, readable and writable
// - loop bit0 tx-to-rx, bit1 rts/cts, bit2 dtr/dsr; all default off
// - report 0x56 holds infrared control; bit0 enables infrared mode
// - infrared transmit pulse centred in bit, 3/16 or 4/16 by bit 2
// - infrared bit1 selects standard or inverted receive data
// - report 0x57 low nibble holds driver enable 0-15 baud times
// - report 0x58 carries 9-bit threshold, bit 8 at offset 1
// - threshold resets to 450, shared by hardware and software flow
// - hardware flow output high above threshold, low at or below
// - software flow queues XOFF above threshold, XON on return
// - report 0x60 get returns stored settings, set programs otp
// - each descriptor field programs once; later attempts ignored
// - select byte at offset 10 picks fields; others unchanged
// - select byte reads back zero
// - descriptor byte layout offsets 1 to 9 as fixed
// - attributes: bit3 wake support, bit2 qualifier, bits1:0 power source
// - flush bits: tx open, tx close, rx open, rx close
// - in software flow mode, received XOFF halts transmit until received XON
`timescale 1ns/1ps
`include "uacr_consts.vh"
module uacr_top #(
  parameter [15:0] VID_RST = 16'h1234, // arbitrary neutral value
  parameter [15:0] PID_RST = 16'h5678  // arbitrary neutral value
) (
  input  wire        I_CLK,
  input  wire        I_RSTN,
  input  wire [11:0] I_ADDR,
  input  wire [7:0]  I_WDATA,
  input  wire        I_WR,
  input  wire        I_RD,
  output reg  [7:0]  O_RDATA,
  input  wire        I_SUB_TICK,
  input  wire        I_BIT_START,
  input  wire        I_TX_SERIAL,
  input  wire        I_RX_SERIAL,
  input  wire        I_IR_RX,
  output reg         O_IR_TX,
  output wire        O_RX_SERIAL,
  output wire        O_LOOP_TX_RX,
  output wire        O_LOOP_RTS_CTS,
  output wire        O_LOOP_DTR_DSR,
  input  wire        I_TX_BUSY,
  input  wire        I_BAUD_TICK,
  output wire        O_DRIVER_EN,
  input  wire [2:0]  I_FLOW_MODE,
  input  wire [9:0]  I_RX_FILL,
  output reg         O_FLOW_REQ,
  output wire        O_FC_VALID,
  output reg  [7:0]  O_FC_CHAR,
  input  wire        I_FC_READY,
  input  wire [7:0]  I_XON_CHAR,
  input  wire [7:0]  I_XOFF_CHAR,
  input  wire        I_RXC_VALID,
  input  wire [7:0]  I_RXC_DATA,
  output reg         O_TX_HALT,
  output wire [15:0] O_VENDOR_ID,
  output wire [15:0] O_PRODUCT_ID,
  output wire [7:0]  O_BUS_CURRENT_BUDGET,
  output wire [7:0]  O_ATTRIBUTES,
  output wire [15:0] O_RELEASE,
  output wire [3:0]  O_FLUSH_POLICY,
  output reg         O_OTP_WRITE,
  output wire [5:0]  O_OTP_PROGRAMMED
);

  //****************************************
  // bus decode
  //****************************************
  wire [7:0] rep_id = I_ADDR[11:4];
  wire [3:0] ofs    = I_ADDR[3:0];
  wire       wr_loop  = I_WR & (rep_id == `UACR_ID_LOOP)  & (ofs == `UACR_OFS_CTRL);
  wire       wr_ir    = I_WR & (rep_id == `UACR_ID_IR)    & (ofs == `UACR_OFS_CTRL);
  wire       wr_delay = I_WR & (rep_id == `UACR_ID_DELAY) & (ofs == `UACR_OFS_CTRL);
  wire       wr_thr   = I_WR & (rep_id == `UACR_ID_THRESH);
  wire       wr_usb   = I_WR & (rep_id == `UACR_ID_USBCFG);

  //****************************************
  // configuration registers
  //****************************************
  reg [2:0] loop_ff;
  reg [2:0] ir_ff;
  reg [3:0] delay_ff;
  reg [8:0] thr_ff;
  always @(posedge I_CLK) begin
    if (!I_RSTN) begin
      loop_ff  <= 3'h0;
      ir_ff    <= 3'h0;
      delay_ff <= 4'h0;
      thr_ff   <= `UACR_THR_RST;
    end else begin
      if (wr_loop)
        loop_ff <= I_WDATA[2:0];
      if (wr_ir)
        ir_ff <= I_WDATA[2:0];
      if (wr_delay)
        delay_ff <= I_WDATA[3:0];
      if (wr_thr && ofs == `UACR_OFS_THR_MSB)
        thr_ff[8] <= I_WDATA[0];
      if (wr_thr && ofs == `UACR_OFS_THR_LSB)
        thr_ff[7:0] <= I_WDATA;
    end
  end
  assign O_LOOP_TX_RX   = loop_ff[0];
  assign O_LOOP_RTS_CTS = loop_ff[1];
  assign O_LOOP_DTR_DSR = loop_ff[2];

  //****************************************
  // descriptor store, each field one-shot
  //****************************************
  // staging takes bytes 1..9; writing the select byte commits
  reg [7:0]  stage_ff [1:9];
  reg [15:0] vid_ff;
  reg [15:0] pid_ff;
  reg [7:0]  power_ff;
  reg [7:0]  attr_ff;
  reg [15:0] rel_ff;
  reg [3:0]  flush_ff;
  reg [5:0]  done_ff;
  wire       commit = wr_usb & (ofs == `UACR_OFS_SELECT);
  wire [5:0] go     = {6{commit}} & I_WDATA[5:0] & ~done_ff;
  // full-width copy so the reset nibble is cut from a net, not from a literal
  wire [7:0] flush_rst = `UACR_FLUSH_RST;
  genvar gi;
  generate
    for (gi = 1; gi <= 9; gi = gi + 1) begin : g_stage
      always @(posedge I_CLK) begin
        if (!I_RSTN)
          stage_ff[gi] <= 8'h00;
        else if (wr_usb && ofs == gi)
          stage_ff[gi] <= I_WDATA;
      end
    end
  endgenerate
  // otp emulation: the store is reloaded to defaults by reset
  always @(posedge I_CLK) begin
    if (!I_RSTN) begin
      vid_ff      <= VID_RST;
      pid_ff      <= PID_RST;
      power_ff    <= `UACR_POWER_RST;
      attr_ff     <= `UACR_ATTR_RST;
      rel_ff      <= `UACR_REL_RST;
      flush_ff    <= flush_rst[3:0];
      done_ff     <= 6'h00;
      O_OTP_WRITE <= 1'b0;
    end else begin
      done_ff     <= done_ff | go;
      O_OTP_WRITE <= |go;
      if (go[`UACR_SEL_VID])
        vid_ff <= {stage_ff[2], stage_ff[1]};
      if (go[`UACR_SEL_PID])
        pid_ff <= {stage_ff[4], stage_ff[3]};
      if (go[`UACR_SEL_ATTR])
        attr_ff <= stage_ff[6] & `UACR_ATTR_MASK;
      if (go[`UACR_SEL_POWER])
        power_ff <= stage_ff[5];
      if (go[`UACR_SEL_REL])
        rel_ff <= {stage_ff[7], stage_ff[8]};
      if (go[`UACR_SEL_FLUSH])
        flush_ff <= stage_ff[9][3:0];
    end
  end
  assign O_VENDOR_ID          = vid_ff;
  assign O_PRODUCT_ID         = pid_ff;
  assign O_BUS_CURRENT_BUDGET = power_ff;
  assign O_ATTRIBUTES         = attr_ff;
  assign O_RELEASE            = rel_ff;
  assign O_FLUSH_POLICY       = flush_ff;
  assign O_OTP_PROGRAMMED     = done_ff;

  //****************************************
  // read path, data one cycle after strobe
  //****************************************
  reg [7:0] nxt_rdata;
  always @* begin
    nxt_rdata = 8'h00;
    case (rep_id)
      `UACR_ID_LOOP:
        if (ofs == `UACR_OFS_CTRL)
          nxt_rdata = {5'h00, loop_ff};
      `UACR_ID_IR:
        if (ofs == `UACR_OFS_CTRL)
          nxt_rdata = {5'h00, ir_ff};
      `UACR_ID_DELAY:
        if (ofs == `UACR_OFS_CTRL)
          nxt_rdata = {4'h0, delay_ff};
      `UACR_ID_THRESH:
        if (ofs == `UACR_OFS_THR_MSB)
          nxt_rdata = {7'h00, thr_ff[8]};
        else if (ofs == `UACR_OFS_THR_LSB)
          nxt_rdata = thr_ff[7:0];
      `UACR_ID_USBCFG:
        case (ofs)
          `UACR_OFS_VID_LO:  nxt_rdata = vid_ff[7:0];
          `UACR_OFS_VID_HI:  nxt_rdata = vid_ff[15:8];
          `UACR_OFS_PID_LO:  nxt_rdata = pid_ff[7:0];
          `UACR_OFS_PID_HI:  nxt_rdata = pid_ff[15:8];
          `UACR_OFS_POWER:   nxt_rdata = power_ff;
          `UACR_OFS_ATTR:    nxt_rdata = attr_ff;
          `UACR_OFS_REL_MAJ: nxt_rdata = rel_ff[15:8];
          `UACR_OFS_REL_MIN: nxt_rdata = rel_ff[7:0];
          `UACR_OFS_FLUSH:   nxt_rdata = {4'h0, flush_ff};
          default:           nxt_rdata = 8'h00;
        endcase
      default:
        nxt_rdata = 8'h00;
    endcase
  end
  always @(posedge I_CLK) begin
    if (!I_RSTN)
      O_RDATA <= 8'h00;
    else if (I_RD)
      O_RDATA <= nxt_rdata;
    else
      O_RDATA <= 8'h00;
  end

  //****************************************
  // infrared encode and receive select
  //****************************************
  reg  [3:0] sub_ff;
  wire [3:0] slot_hi = ir_ff[2] ? `UACR_IR_SLOT_HI4 : `UACR_IR_SLOT_HI3;
  wire       in_slot = (sub_ff >= `UACR_IR_SLOT_LO) && (sub_ff <= slot_hi);
  always @(posedge I_CLK) begin
    if (!I_RSTN) begin
      sub_ff  <= 4'h0;
      O_IR_TX <= 1'b0;
    end else begin
      if (I_BIT_START)
        sub_ff <= 4'h0;
      else if (I_SUB_TICK)
        sub_ff <= sub_ff + 4'h1;
      // a zero bit is sent as a light pulse; a one is dark
      O_IR_TX <= ir_ff[0] & ~I_TX_SERIAL & in_slot;
    end
  end
  // standard receive pulses are active high for a zero bit
  wire ir_rx_data = ir_ff[1] ? I_IR_RX : ~I_IR_RX;
  wire pin_rx     = ir_ff[0] ? ir_rx_data : I_RX_SERIAL;
  assign O_RX_SERIAL = loop_ff[0] ? I_TX_SERIAL : pin_rx;

  //****************************************
  // driver enable hold-off
  //****************************************
  reg [3:0] hold_ff;
  reg       drv_ff;
  always @(posedge I_CLK) begin
    if (!I_RSTN) begin
      hold_ff <= 4'h0;
      drv_ff  <= 1'b0;
    end else if (I_TX_BUSY) begin
      hold_ff <= delay_ff;
      drv_ff  <= 1'b1;
    end else if (drv_ff && I_BAUD_TICK) begin
      if (hold_ff == 4'h0)
        drv_ff <= 1'b0;
      else
        hold_ff <= hold_ff - 4'h1;
    end else if (drv_ff && hold_ff == 4'h0) begin
      drv_ff <= 1'b0;
    end
  end
  assign O_DRIVER_EN = I_TX_BUSY | drv_ff;

  //****************************************
  // flow control
  //****************************************
  wire above = I_RX_FILL > {1'b0, thr_ff};
  wire sw_fc = I_FLOW_MODE == `UACR_FLOW_SW;
  reg  above_ff;
  reg  fc_pend_ff;
  assign O_FC_VALID = fc_pend_ff;
  always @(posedge I_CLK) begin
    if (!I_RSTN) begin
      O_FLOW_REQ <= 1'b0;
      above_ff   <= 1'b0;
      fc_pend_ff <= 1'b0;
      O_FC_CHAR  <= 8'h00;
      O_TX_HALT  <= 1'b0;
    end else begin
      O_FLOW_REQ <= (I_FLOW_MODE == `UACR_FLOW_HW) & above;
      // a pending char is replaced if the level crosses back first
      if (sw_fc && above != above_ff) begin
        above_ff   <= above;
        fc_pend_ff <= 1'b1;
        O_FC_CHAR  <= above ? I_XOFF_CHAR : I_XON_CHAR;
      end else if (fc_pend_ff && I_FC_READY) begin
        fc_pend_ff <= 1'b0;
      end
      if (!sw_fc)
        O_TX_HALT <= 1'b0;
      else if (I_RXC_VALID && I_RXC_DATA == I_XOFF_CHAR)
        O_TX_HALT <= 1'b1;
      else if (I_RXC_VALID && I_RXC_DATA == I_XON_CHAR)
        O_TX_HALT <= 1'b0;
    end
  end

endmodule

// *** tb/uacr_txq_model.sv ***
// flow character sink standing in for the transmit queue
`timescale 1ns/1ps
module uacr_txq_model (
  input  wire       i_clk,
  input  wire       i_rst_n,
  input  wire       i_fc_valid,
  input  wire [7:0] i_fc_char,
  input  wire [3:0] i_stall,
  output reg        o_fc_ready,
  output reg  [7:0] o_last_char
);
  // *****
  // accept
  // *****
  reg [3:0] cnt_ff;
  // ready lasts one cycle so a char is never taken twice
  always @(posedge i_clk) begin
    if (i_fc_valid && o_fc_ready) begin
      o_last_char <= i_fc_char;
    end
    if (!i_rst_n || !i_fc_valid || o_fc_ready) begin
      cnt_ff     <= 4'h0;
      o_fc_ready <= 1'b0;
    end else if (cnt_ff == i_stall) begin
      o_fc_ready <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end
endmodule

// *** tb/uacr_chk_asserts.sv ***
// port assertions for the report decoder
`timescale 1ns/1ps
module uacr_chk (
  input wire        I_CLK,
  input wire        I_RSTN,
  input wire [11:0] I_ADDR,
  input wire [7:0]  I_WDATA,
  input wire        I_WR,
  input wire        I_RD,
  input wire [7:0]  O_RDATA,
  input wire        O_LOOP_TX_RX,
  input wire        O_LOOP_RTS_CTS,
  input wire        O_LOOP_DTR_DSR,
  input wire        I_TX_BUSY,
  input wire        O_DRIVER_EN,
  input wire [2:0]  I_FLOW_MODE,
  input wire        O_FC_VALID,
  input wire        I_FC_READY,
  input wire [7:0]  I_XOFF_CHAR,
  input wire        I_RXC_VALID,
  input wire [7:0]  I_RXC_DATA,
  input wire        O_TX_HALT,
  input wire        O_OTP_WRITE,
  input wire [5:0]  O_OTP_PROGRAMMED
);
  // *****
  // checks
  // *****
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);
  sequence loop_wr_s;
    I_WR && I_ADDR == 12'h551;
  endsequence
  sequence xoff_rx_s;
    I_FLOW_MODE == 3'h2 && I_RXC_VALID && I_RXC_DATA == I_XOFF_CHAR;
  endsequence
  rd_idle_zero_a: assert property (
    !$past(I_RD) |-> O_RDATA == 8'h00) else $error("read data not idle zero");
  loop_set_a: assert property (
    loop_wr_s |=> {O_LOOP_DTR_DSR, O_LOOP_RTS_CTS, O_LOOP_TX_RX} == $past(I_WDATA[2:0]))
    else $error("loop bits not written");
  loop_read_a: assert property (
    I_RD && I_ADDR == 12'h551 |=> O_RDATA == {5'h00, O_LOOP_DTR_DSR, O_LOOP_RTS_CTS,
    O_LOOP_TX_RX}) else $error("loop byte read wrong");
  // checked one cycle on, so drv_ff has to carry the enable past busy
  drv_busy_a: assert property (
    I_TX_BUSY |=> O_DRIVER_EN) else $error("driver off after busy");
  otp_pulse_a: assert property (
    O_OTP_WRITE |-> $past(I_WR && I_ADDR == 12'h60A) ##1 !O_OTP_WRITE)
    else $error("otp write pulse wrong");
  otp_once_a: assert property (
    ($past(O_OTP_PROGRAMMED) & ~O_OTP_PROGRAMMED) == 6'h00) else $error("programmed flag lost");
  prog_commit_a: assert property (
    O_OTP_PROGRAMMED != $past(O_OTP_PROGRAMMED) |-> O_OTP_WRITE)
    else $error("field programmed without commit");
  fc_hold_a: assert property (
    O_FC_VALID && !I_FC_READY && I_FLOW_MODE == 3'h2 |=> O_FC_VALID)
    else $error("flow char dropped");
  halt_set_a: assert property (
    xoff_rx_s |=> O_TX_HALT) else $error("no halt after xoff");
endmodule
bind uacr_top uacr_chk u_chk (.*);

// *** tb/testbench.sv ***
// scenario testbench for the report decoder
`timescale 1ns/1ps
module testbench;
  reg         I_CLK, I_RSTN, I_WR, I_RD, I_SUB_TICK, I_BIT_START, I_TX_SERIAL;
  reg         I_RX_SERIAL, I_IR_RX, I_TX_BUSY, I_BAUD_TICK, I_RXC_VALID;
  reg  [11:0] I_ADDR;
  reg  [7:0]  I_WDATA, I_RXC_DATA;
  reg  [2:0]  I_FLOW_MODE;
  reg  [9:0]  I_RX_FILL;
  reg  [3:0]  stall;
  wire [7:0]  I_XON_CHAR = 8'h11;
  wire [7:0]  I_XOFF_CHAR = 8'h13;
  wire [7:0]  O_RDATA, O_FC_CHAR, O_BUS_CURRENT_BUDGET, O_ATTRIBUTES, got_char;
  wire [15:0] O_VENDOR_ID, O_PRODUCT_ID, O_RELEASE;
  wire [5:0]  O_OTP_PROGRAMMED;
  wire [3:0]  O_FLUSH_POLICY;
  wire        O_IR_TX, O_RX_SERIAL, O_LOOP_TX_RX, O_LOOP_RTS_CTS, O_LOOP_DTR_DSR;
  wire        O_DRIVER_EN, O_FLOW_REQ, O_FC_VALID, I_FC_READY, O_TX_HALT, O_OTP_WRITE;
  integer     compares, miscompares;
  // id values are arbitrary
  uacr_top #(.VID_RST(16'h1234), .PID_RST(16'h5678)) DUT (.*);
  uacr_txq_model txq (.i_clk(I_CLK), .i_rst_n(I_RSTN), .i_fc_valid(O_FC_VALID),
    .i_fc_char(O_FC_CHAR), .i_stall(stall), .o_fc_ready(I_FC_READY), .o_last_char(got_char));
  // *****
  // helpers
  // *****
  task chk(input [15:0] got, input [15:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task close_out;
    begin
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge I_CLK);
      #1;
    end
  endtask
  // a gap edge between strobes keeps one assignment per time step
  task wr(input [11:0] a, input [7:0] d);
    begin
      @(posedge I_CLK) {I_ADDR, I_WDATA, I_WR} <= {a, d, 1'b1};
      @(posedge I_CLK) I_WR <= 1'b0;
      #1;
    end
  endtask
  task rd(input [11:0] a, input [7:0] e);
    begin
      @(posedge I_CLK) {I_ADDR, I_RD} <= {a, 1'b1};
      @(posedge I_CLK) I_RD <= 1'b0;
      #1 chk(O_RDATA, e);
    end
  endtask
  task rx_char(input [7:0] c);
    begin
      @(posedge I_CLK) {I_RXC_DATA, I_RXC_VALID} <= {c, 1'b1};
      @(posedge I_CLK) I_RXC_VALID <= 1'b0;
      #1;
    end
  endtask
  task ticks(input integer n);
    repeat (n) begin
      @(posedge I_CLK) I_BAUD_TICK <= 1'b1;
      @(posedge I_CLK) I_BAUD_TICK <= 1'b0;
    end
  endtask
  task fc_wait(input [7:0] e);
    integer n;
    begin
      n = 0;
      while (!(got_char === e && O_FC_VALID === 1'b0) && n < 30) begin
        cyc(1);
        n = n + 1;
      end
      chk(got_char, e);
      // a wait that runs out is a failure in its own right
      if (n == 30) begin
        miscompares = miscompares + 1;
        close_out;
      end
    end
  endtask
  // *****
  // scenarios
  // *****
  task t_defaults;
    begin
      rd(12'h551, 8'h00);
      rd(12'h561, 8'h00);
      rd(12'h571, 8'h00);
      rd(12'h581, 8'h01);
      rd(12'h582, 8'hC2);
      rd(12'h601, 8'h34);
      rd(12'h602, 8'h12);
      rd(12'h603, 8'h78);
      rd(12'h604, 8'h56);
      rd(12'h605, 8'h32);
      rd(12'h606, 8'h00);
      rd(12'h607, 8'h01);
      rd(12'h608, 8'h00);
      rd(12'h609, 8'h05);
      rd(12'h60A, 8'h00);
      rd(12'h7F0, 8'h00);
    end
  endtask
  task t_loop_ir;
    begin
      wr(12'h551, 8'hFF);
      chk({O_LOOP_DTR_DSR, O_LOOP_RTS_CTS, O_LOOP_TX_RX}, 3'h7);
      @(posedge I_CLK) I_TX_SERIAL <= 1'b1;
      #1 chk(O_RX_SERIAL, 1'b1);
      rd(12'h551, 8'h07);
      wr(12'h551, 8'h00);
      chk(O_RX_SERIAL, 1'b0);
      wr(12'h561, 8'hF9);
      rd(12'h561, 8'h01);
      @(posedge I_CLK) I_IR_RX <= 1'b1;
      #1 chk(O_RX_SERIAL, 1'b0);
      wr(12'h561, 8'h07);
      chk(O_RX_SERIAL, 1'b1);
      wr(12'h561, 8'h00);
      chk(O_RX_SERIAL, 1'b0);
    end
  endtask
  // one zero bit at a sub tick per clock: 3 or 4 lit ticks from tick 6, none when off
  task t_ir_tx;
    integer k, j, n, first;
    begin
      for (k = 0; k < 3; k = k + 1) begin
        wr(12'h561, (k == 0) ? 8'h01 : (k == 1) ? 8'h05 : 8'h04);
        @(posedge I_CLK) {I_TX_SERIAL, I_BIT_START} <= 2'b01;
        @(posedge I_CLK) {I_BIT_START, I_SUB_TICK} <= 2'b01;
        n = 0;
        first = 0;
        for (j = 0; j < 16; j = j + 1) begin
          cyc(1);
          if (O_IR_TX === 1'b1 && n == 0) first = j;
          if (O_IR_TX === 1'b1) n = n + 1;
        end
        @(posedge I_CLK) {I_SUB_TICK, I_TX_SERIAL} <= 2'b01;
        chk(n, (k == 0) ? 16'h0003 : (k == 1) ? 16'h0004 : 16'h0000);
        chk(first, (k == 2) ? 16'h0000 : 16'h0006);
      end
    end
  endtask
  task t_delay;
    begin
      wr(12'h571, 8'hF3);
      rd(12'h571, 8'h03);
      @(posedge I_CLK) I_TX_BUSY <= 1'b1;
      @(posedge I_CLK) I_TX_BUSY <= 1'b0;
      ticks(3);
      #1 chk(O_DRIVER_EN, 1'b1);
      cyc(1);
      chk(O_DRIVER_EN, 1'b0);
    end
  endtask
  task t_flow;
    begin
      wr(12'h581, 8'h00);
      wr(12'h582, 8'h05);
      @(posedge I_CLK) {I_FLOW_MODE, I_RX_FILL} <= {3'h1, 10'h005};
      cyc(3);
      chk(O_FLOW_REQ, 1'b0);
      @(posedge I_CLK) I_RX_FILL <= 10'h006;
      cyc(2);
      chk(O_FLOW_REQ, 1'b1);
      wr(12'h581, 8'hFF);
      rd(12'h581, 8'h01);
      chk(O_FLOW_REQ, 1'b0);
      @(posedge I_CLK) I_RX_FILL <= 10'h106;
      cyc(2);
      chk(O_FLOW_REQ, 1'b1);
      wr(12'h581, 8'h00);
      @(posedge I_CLK) I_RX_FILL <= 10'h005;
      @(posedge I_CLK) I_FLOW_MODE <= 3'h2;
      cyc(3);
      chk(O_FC_VALID, 1'b0);
      @(posedge I_CLK) I_RX_FILL <= 10'h006;
      fc_wait(8'h13);
      @(posedge I_CLK) {I_RX_FILL, stall} <= {10'h005, 4'h0};
      fc_wait(8'h11);
      rx_char(8'h13);
      chk(O_TX_HALT, 1'b1);
      rx_char(8'h11);
      chk(O_TX_HALT, 1'b0);
    end
  endtask
  task t_otp;
    begin
      wr(12'h601, 8'hAA);
      wr(12'h602, 8'hBB);
      wr(12'h605, 8'hFA);
      wr(12'h60A, 8'h09);
      chk(O_OTP_WRITE, 1'b1);
      cyc(1);
      chk(O_OTP_WRITE, 1'b0);
      chk(O_VENDOR_ID, 16'hBBAA);
      chk(O_BUS_CURRENT_BUDGET, 8'hFA);
      chk(O_PRODUCT_ID, 16'h5678);
      chk(O_OTP_PROGRAMMED, 6'h09);
      rd(12'h60A, 8'h00);
      rd(12'h602, 8'hBB);
      wr(12'h601, 8'h11);
      wr(12'h603, 8'h22);
      wr(12'h604, 8'h33);
      wr(12'h606, 8'hFF);
      wr(12'h607, 8'h02);
      wr(12'h608, 8'h10);
      wr(12'h609, 8'hF0);
      wr(12'h60A, 8'hFF);
      cyc(1);
      chk(O_VENDOR_ID, 16'hBBAA);
      chk(O_PRODUCT_ID, 16'h3322);
      chk(O_ATTRIBUTES, 8'h0F);
      chk(O_RELEASE, 16'h0210);
      chk(O_FLUSH_POLICY, 4'h0);
      chk(O_OTP_PROGRAMMED, 6'h3F);
      wr(12'h60A, 8'h3F);
      chk(O_OTP_WRITE, 1'b0);
      rd(12'h606, 8'h0F);
    end
  endtask
  initial begin
    I_CLK = 1'b0;
    forever #25 I_CLK = ~I_CLK;
  end
  initial begin
    {I_RSTN, I_WR, I_RD, I_SUB_TICK, I_BIT_START, I_TX_SERIAL, I_RX_SERIAL} = 7'h00;
    {I_IR_RX, I_TX_BUSY, I_BAUD_TICK, I_RXC_VALID, I_RXC_DATA} = 12'h000;
    {I_ADDR, I_WDATA, I_FLOW_MODE, I_RX_FILL, stall} = 37'h3;
    compares = 0;
    miscompares = 0;
    repeat (12) @(posedge I_CLK);
    I_RSTN <= 1'b1;
    t_defaults;
    t_loop_ir;
    t_ir_tx;
    t_delay;
    t_flow;
    t_otp;
    close_out;
  end
endmodule
